// ### rtl/hwtp_pkg.sv
// shared constants for the hardware-source trace packetizer
package hwtp_pkg;
  // register byte offsets
  localparam logic [11:0] OFF_CONTROL    = 12'h000;
  localparam logic [11:0] OFF_CMP_FUNC   = 12'h004;
  localparam logic [11:0] OFF_STATUS     = 12'h008;
  localparam logic [11:0] OFF_CYCLE      = 12'h00C;
  // control register fields
  localparam int          CTL_SAMPLE_EN  = 0;
  localparam int          CTL_TAP_SEL    = 1;
  localparam int          CTL_RELOAD_LO  = 2;
  localparam int          RELOAD_W       = 4;
  localparam logic [3:0]  RELOAD_RESET   = 4'h0;
  // comparator function field: one 3-bit field per traced comparator
  localparam int          CFG_W          = 3;
  localparam int          CFG_EMIT_VALUE = 0;
  localparam int          CFG_EMIT_PC    = 1;
  localparam int          CFG_EMIT_ADDR  = 2;
  localparam int          TRACED_CMPS    = 4;
  localparam logic [3:0]  MAX_TRACED_IDX = 4'h3;
  // cycle counter tap masks: all-ones low bits mean a carry into the tap bit
  localparam logic [31:0] TAP_MASK_LO    = 32'h0000003F;
  localparam logic [31:0] TAP_MASK_HI    = 32'h000003FF;
  // header fields
  localparam logic [4:0]  ID_EXCEPTION   = 5'h01;
  localparam logic [4:0]  ID_PC_SAMPLE   = 5'h02;
  localparam logic [1:0]  SS_NONE        = 2'h0;
  localparam logic [1:0]  SS_ONE         = 2'h1;
  localparam logic [1:0]  SS_TWO         = 2'h2;
  localparam logic [1:0]  SS_FOUR        = 2'h3;
  localparam logic        HW_SOURCE      = 1'b1;
  localparam logic [1:0]  DT_PC_OR_ADDR  = 2'h1;
  localparam logic [1:0]  DT_VALUE       = 2'h2;
  localparam logic [1:0]  ACT_RESERVED   = 2'h0;
  // pending packet slots, in no particular order
  localparam int          PEND_EXC       = 0;
  localparam int          PEND_SMP       = 1;
  localparam int          PEND_DTA       = 2;
  localparam int          PEND_DTB       = 3;
  localparam int          PEND_N         = 4;
endpackage

// ### rtl/hwtp_pkt_if.sv
// one finished packet passing from the packet builder to the output slot
`timescale 1ns/1ns
interface hwtp_pkt_if;
  logic        valid;
  logic        ready;
  logic [7:0]  header;
  logic [31:0] payload;
  modport src (output valid, output header, output payload, input ready);
  modport dst (input valid, input header, input payload, output ready);
endinterface // hwtp_pkt_if

// ### rtl/hwtp_sampler.sv
// cycle counter, tap selection and post-scaler that time the pc samples
`timescale 1ns/1ns
module hwtp_sampler #(
  parameter int RELOAD_W = 4
) (
  // clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // configuration
  input  wire logic                enable,
  input  wire logic                tap_select,
  input  wire logic [RELOAD_W-1:0] reload,
  // state and timing
  output logic      [31:0]         cycle_counter,
  output logic                     sample_tick
);
  logic [RELOAD_W-1:0] sample_post_scaler;
  logic                tap_event;

  // carry into the chosen tap bit of the cycle counter
  assign tap_event = ((cycle_counter & (tap_select ? hwtp_pkg::TAP_MASK_HI
                                                   : hwtp_pkg::TAP_MASK_LO))
                      == (tap_select ? hwtp_pkg::TAP_MASK_HI : hwtp_pkg::TAP_MASK_LO));

  // free-running processor cycle counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cycle_counter <= 32'h00000000;
    end else begin
      cycle_counter <= cycle_counter + 32'h00000001;
    end
  end

  // post-scaler counts tap events down; its period is the sample interval
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_post_scaler <= '0;
      sample_tick        <= 1'b0;
    end else if (!enable) begin
      sample_post_scaler <= reload;
      sample_tick        <= 1'b0;
    end else if (tap_event) begin
      sample_tick        <= (sample_post_scaler == '0);
      sample_post_scaler <= (sample_post_scaler == '0) ? reload
                                                       : sample_post_scaler - 1'b1;
    end else begin
      sample_tick        <= 1'b0;
    end
  end
endmodule // hwtp_sampler

// ### rtl/hwtp_out_slot.sv
// one-packet output buffer toward the trace multiplexer
`timescale 1ns/1ns
module hwtp_out_slot (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // from the packet builder
  hwtp_pkt_if.dst          in_pkt,
  // toward the trace multiplexer
  output logic             out_valid,
  output logic [7:0]       out_header,
  output logic [31:0]      out_payload,
  input  wire logic        out_ready
);
  // ready when empty; when full, a new packet only enters as the old one leaves
  assign in_pkt.ready = !out_valid || out_ready;

  // hold the packet until the multiplexer takes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid   <= 1'b0;
      out_header  <= 8'h00;
      out_payload <= 32'h00000000;
    end else if (in_pkt.ready) begin
      out_valid <= in_pkt.valid;
      if (in_pkt.valid) begin
        out_header  <= in_pkt.header;
        out_payload <= in_pkt.payload;
      end
    end
  end
endmodule // hwtp_out_slot

// ### rtl/hwtp_packetizer.sv
// hardware-source trace packet builder with apb registers
`timescale 1ns/1ns
module hwtp_packetizer #(
  parameter int IDX_W = 4
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic                  pready,
  output logic      [31:0]      prdata,
  output logic                  pslverr,
  // exception events from the core
  input  wire logic             exc_valid,
  input  wire logic [8:0]       exception_id,
  input  wire logic [1:0]       exception_action,
  // core state for pc sampling
  input  wire logic [31:0]      core_pc,
  input  wire logic             core_sleeping,
  // comparator matches
  input  wire logic             cmp_match,
  input  wire logic [IDX_W-1:0] comparator_index,
  input  wire logic [31:0]      match_pc,
  input  wire logic [31:0]      match_addr,
  input  wire logic [31:0]      match_value,
  input  wire logic [1:0]       match_size,
  input  wire logic             write_not_read,
  // toward the trace packet mux
  output logic                  trc_valid,
  output logic      [7:0]       trc_header,
  output logic      [31:0]      trc_payload,
  input  wire logic             trc_ready,
  output logic                  overflow_req
);
  localparam int N = hwtp_pkg::PEND_N;
  localparam int E = hwtp_pkg::PEND_EXC;
  localparam int S = hwtp_pkg::PEND_SMP;
  localparam int A = hwtp_pkg::PEND_DTA;
  localparam int B = hwtp_pkg::PEND_DTB;

  // watch_control_reg fields and other software state
  logic                          pc_sample_enable;
  logic                          cycle_tap_select;
  logic [hwtp_pkg::RELOAD_W-1:0] post_reload;
  logic [11:0]                   comparator_function_cfg;
  logic [15:0]                   overflow_count;
  logic [31:0]                   cycle_counter;
  logic                          sample_tick;
  // apb decode
  logic                          addr_hit;
  logic                          wr_en;
  logic [31:0]                   next_prdata;
  // packet sources
  logic                          exc_ok;
  logic                          cmp_ok;
  logic [1:0]                    cmp_num;
  logic [2:0]                    cfg;
  logic                          emit_value;
  logic                          emit_pc;
  logic                          emit_address_flag;
  logic                          dta_need;
  logic                          dtb_need;
  logic [31:0]                   value_masked;
  logic [7:0]                    new_hdr [N];
  logic [31:0]                   new_pl  [N];
  // pending packets and arbitration
  logic [N-1:0]                  pend_v;
  logic [7:0]                    pend_hdr [N];
  logic [31:0]                   pend_pl  [N];
  logic [N-1:0]                  grant;
  logic [N-1:0]                  free;
  logic [N-1:0]                  load;
  logic                          data_free;
  logic                          drop;

  hwtp_pkt_if pkt ();

  // sample timing
  hwtp_sampler #(
    .RELOAD_W (hwtp_pkg::RELOAD_W)
  ) u_sampler (
    .pclk          (pclk),
    .presetn       (presetn),
    .enable        (pc_sample_enable),
    .tap_select    (cycle_tap_select),
    .reload        (post_reload),
    .cycle_counter (cycle_counter),
    .sample_tick   (sample_tick)
  );

  // output buffer
  hwtp_out_slot u_slot (
    .pclk        (pclk),
    .presetn     (presetn),
    .in_pkt      (pkt),
    .out_valid   (trc_valid),
    .out_header  (trc_header),
    .out_payload (trc_payload),
    .out_ready   (trc_ready)
  );

  // apb handshake: zero wait states, error on unmapped address
  assign pready   = 1'b1;
  assign addr_hit = (paddr == hwtp_pkg::OFF_CONTROL) || (paddr == hwtp_pkg::OFF_CMP_FUNC) ||
                    (paddr == hwtp_pkg::OFF_STATUS)  || (paddr == hwtp_pkg::OFF_CYCLE);
  assign pslverr  = psel && penable && !addr_hit;
  assign wr_en    = psel && penable && pwrite;

  // read mux, sampled in the setup cycle so read data comes from a flop
  always_comb begin
    next_prdata = 32'h00000000;
    unique case (paddr)
      hwtp_pkg::OFF_CONTROL: begin
        next_prdata[hwtp_pkg::CTL_SAMPLE_EN] = pc_sample_enable;
        next_prdata[hwtp_pkg::CTL_TAP_SEL]   = cycle_tap_select;
        next_prdata[hwtp_pkg::CTL_RELOAD_LO +: hwtp_pkg::RELOAD_W] = post_reload;
      end
      hwtp_pkg::OFF_CMP_FUNC: next_prdata[11:0]  = comparator_function_cfg;
      hwtp_pkg::OFF_STATUS:   next_prdata[15:0]  = overflow_count;
      hwtp_pkg::OFF_CYCLE:    next_prdata        = cycle_counter;
      default:                next_prdata        = 32'h00000000;
    endcase
  end

  // read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // control and comparator configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_sample_enable        <= 1'b0;
      cycle_tap_select        <= 1'b0;
      post_reload             <= hwtp_pkg::RELOAD_RESET;
      comparator_function_cfg <= 12'h000;
    end else if (wr_en && paddr == hwtp_pkg::OFF_CONTROL) begin
      pc_sample_enable <= pwdata[hwtp_pkg::CTL_SAMPLE_EN];
      cycle_tap_select <= pwdata[hwtp_pkg::CTL_TAP_SEL];
      post_reload      <= pwdata[hwtp_pkg::CTL_RELOAD_LO +: hwtp_pkg::RELOAD_W];
    end else if (wr_en && paddr == hwtp_pkg::OFF_CMP_FUNC) begin
      comparator_function_cfg <= pwdata[11:0];
    end
  end

  // exception packet: id split over two bytes, reserved bits zero
  assign exc_ok   = exc_valid && (exception_action != hwtp_pkg::ACT_RESERVED);
  assign new_hdr[E] = {hwtp_pkg::ID_EXCEPTION, hwtp_pkg::HW_SOURCE, hwtp_pkg::SS_TWO};
  assign new_pl[E]  = {16'h0000, 2'b00, exception_action, 3'b000, exception_id[8],
                       exception_id[7:0]};

  // periodic sample: full pc or zero sleep byte
  assign new_hdr[S] = core_sleeping
                    ? {hwtp_pkg::ID_PC_SAMPLE, hwtp_pkg::HW_SOURCE, hwtp_pkg::SS_ONE}
                    : {hwtp_pkg::ID_PC_SAMPLE, hwtp_pkg::HW_SOURCE, hwtp_pkg::SS_FOUR};
  assign new_pl[S]  = core_sleeping ? 32'h00000000
                                    : {core_pc[31:1], 1'b0};

  // comparator decode; only the low four comparators can trace data
  assign cmp_ok  = cmp_match && (comparator_index <= IDX_W'(hwtp_pkg::MAX_TRACED_IDX));
  assign cmp_num = comparator_index[1:0];
  assign cfg     = comparator_function_cfg[cmp_num * hwtp_pkg::CFG_W +: hwtp_pkg::CFG_W];
  assign emit_value        = cfg[hwtp_pkg::CFG_EMIT_VALUE] && (match_size != hwtp_pkg::SS_NONE);
  assign emit_address_flag = cfg[hwtp_pkg::CFG_EMIT_ADDR];
  assign emit_pc           = cfg[hwtp_pkg::CFG_EMIT_PC] && !emit_address_flag;
  assign dta_need = cmp_ok && (emit_pc || emit_address_flag);
  assign dtb_need = cmp_ok && emit_value;

  // first data packet: instruction pc or low address half
  assign new_hdr[A] = {hwtp_pkg::DT_PC_OR_ADDR, cmp_num, emit_address_flag, hwtp_pkg::HW_SOURCE,
                       emit_address_flag ? hwtp_pkg::SS_TWO : hwtp_pkg::SS_FOUR};
  assign new_pl[A]  = emit_address_flag ? {16'h0000, match_addr[15:0]}
                                        : match_pc;

  // data value packet, payload sized by the transfer
  assign new_hdr[B] = {hwtp_pkg::DT_VALUE, cmp_num, write_not_read, hwtp_pkg::HW_SOURCE,
                       match_size};
  always_comb begin
    value_masked = match_value;
    if (match_size == hwtp_pkg::SS_ONE) begin
      value_masked = {24'h000000, match_value[7:0]};
    end else if (match_size == hwtp_pkg::SS_TWO) begin
      value_masked = {16'h0000, match_value[15:0]};
    end
  end
  assign new_pl[B] = value_masked;

  // fixed priority: exception, data pair in order, then sample
  always_comb begin
    grant = '0;
    if (pkt.ready) begin
      if (pend_v[E]) begin
        grant[E] = 1'b1;
      end else if (pend_v[A]) begin
        grant[A] = 1'b1;
      end else if (pend_v[B]) begin
        grant[B] = 1'b1;
      end else if (pend_v[S]) begin
        grant[S] = 1'b1;
      end
    end
  end

  // a slot is free if empty or leaving this cycle; a match needs both data slots
  assign free      = ~pend_v | grant;
  assign data_free = free[A] && free[B];
  assign load[E]   = exc_ok && free[E];
  assign load[S]   = sample_tick && free[S];
  assign load[A]   = dta_need && data_free;
  assign load[B]   = dtb_need && data_free;
  assign drop      = (exc_ok && !free[E]) || (sample_tick && !free[S]) ||
                     ((dta_need || dtb_need) && !data_free);

  // pending packets waiting for the output buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_v <= '0;
      for (int k = 0; k < N; k++) begin
        pend_hdr[k] <= 8'h00;
        pend_pl[k]  <= 32'h00000000;
      end
    end else begin
      for (int k = 0; k < N; k++) begin
        if (load[k]) begin
          pend_v[k]   <= 1'b1;
          pend_hdr[k] <= new_hdr[k];
          pend_pl[k]  <= new_pl[k];
        end else if (grant[k]) begin
          pend_v[k] <= 1'b0;
        end
      end
    end
  end

  // granted packet toward the output buffer
  always_comb begin
    pkt.valid   = |grant;
    pkt.header  = 8'h00;
    pkt.payload = 32'h00000000;
    for (int k = 0; k < N; k++) begin
      if (grant[k]) begin
        pkt.header  = pend_hdr[k];
        pkt.payload = pend_pl[k];
      end
    end
  end

  // overflow request pulse and its counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_req   <= 1'b0;
      overflow_count <= 16'h0000;
    end else begin
      overflow_req <= drop;
      if (drop) begin
        overflow_count <= overflow_count + 16'h0001;
      end
    end
  end

  // exception header and size code
  property p_exc_header;
    @(posedge pclk) disable iff (!presetn)
    grant[E] |-> pkt.header == {hwtp_pkg::ID_EXCEPTION, hwtp_pkg::HW_SOURCE, hwtp_pkg::SS_TWO};
  endproperty
  a_exc_header: assert property (p_exc_header) else $error("bad exception header");

  // exception id captured across two payload bytes
  property p_exc_id;
    @(posedge pclk) disable iff (!presetn)
    load[E] |=> pend_pl[E][7:0] == $past(exception_id[7:0]) && pend_pl[E][8] == $past(exception_id[8]);
  endproperty
  a_exc_id: assert property (p_exc_id) else $error("exception id misplaced");

  // emitted exception action never reserved
  property p_exc_action;
    @(posedge pclk) disable iff (!presetn)
    grant[E] |-> pkt.payload[13:12] != hwtp_pkg::ACT_RESERVED;
  endproperty
  a_exc_action: assert property (p_exc_action) else $error("reserved action emitted");

  // reserved exception bits zero
  property p_exc_reserved;
    @(posedge pclk) disable iff (!presetn)
    grant[E] |-> pkt.payload[15:14] == 2'h0 && pkt.payload[11:9] == 3'h0;
  endproperty
  a_exc_reserved: assert property (p_exc_reserved) else $error("reserved bits set");

  // no sample while sampling is off
  property p_sample_enable;
    @(posedge pclk) disable iff (!presetn)
    !pc_sample_enable ##1 !pc_sample_enable |-> !sample_tick;
  endproperty
  a_sample_enable: assert property (p_sample_enable) else $error("sample while off");

  // sleep sample header and zero byte
  property p_sleep_sample;
    @(posedge pclk) disable iff (!presetn)
    load[S] && core_sleeping |=> pend_pl[S] == 32'h00000000 &&
      pend_hdr[S] == {hwtp_pkg::ID_PC_SAMPLE, hwtp_pkg::HW_SOURCE, hwtp_pkg::SS_ONE};
  endproperty
  a_sleep_sample: assert property (p_sleep_sample) else $error("bad sleep sample");

  // sample pc low bit cleared
  property p_pc_align;
    @(posedge pclk) disable iff (!presetn)
    grant[S] |-> !pkt.payload[0];
  endproperty
  a_pc_align: assert property (p_pc_align) else $error("sample pc bit 0 set");

  // high comparators make no data packets
  property p_high_cmp;
    @(posedge pclk) disable iff (!presetn)
    comparator_index > IDX_W'(hwtp_pkg::MAX_TRACED_IDX) |-> !load[A] && !load[B];
  endproperty
  a_high_cmp: assert property (p_high_cmp) else $error("high comparator traced");

  // value packet never overtakes its leading packet
  property p_pair_order;
    @(posedge pclk) disable iff (!presetn)
    grant[B] |-> !pend_v[A];
  endproperty
  a_pair_order: assert property (p_pair_order) else $error("pair out of order");

  // every header hardware-sourced with a legal size
  property p_header_common;
    @(posedge pclk) disable iff (!presetn)
    pkt.valid |-> pkt.header[2] && pkt.header[1:0] != hwtp_pkg::SS_NONE;
  endproperty
  a_header_common: assert property (p_header_common) else $error("bad header");

  // dropped exception raises overflow next cycle
  property p_overflow;
    @(posedge pclk) disable iff (!presetn)
    exc_ok && !free[E] |=> overflow_req && overflow_count == $past(overflow_count) + 16'h0001;
  endproperty
  a_overflow: assert property (p_overflow) else $error("drop without overflow");
endmodule // hwtp_packetizer

// ### test/hwtp_mux_model.sv
// behavioural trace packet mux that accepts and logs finished packets
`timescale 1ns/1ns
module hwtp_mux_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // packet side
  input  wire logic        trc_valid,
  input  wire logic [7:0]  trc_header,
  input  wire logic [31:0] trc_payload,
  output logic             trc_ready,
  input  wire logic        overflow_req,
  // back-pressure asked by the bench
  input  wire logic        stall
);
  logic [7:0]  hq[$];
  logic [31:0] pq[$];
  int          tq[$];
  int          cyc = 0;
  int          ovf = 0;

  // accepts every cycle unless told to stall
  assign trc_ready = !stall;

  // logs accepted packets with their cycle, and counts drop pulses
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (presetn && trc_valid === 1'b1 && trc_ready) begin
      hq.push_back(trc_header);
      pq.push_back(trc_payload);
      tq.push_back(cyc);
    end
    if (overflow_req === 1'b1) begin
      ovf <= ovf + 1;
    end
  end
endmodule // hwtp_mux_model

// ### test/hw_source_trace_packetizer_tb_top.sv
// testbench of the packetizer with apb access and a logging trace mux
`timescale 1ns/1ns
module hw_source_trace_packetizer_tb_top;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, core_pc = 0;
  logic        pready, pslverr, er, exc_valid = 0, core_sleeping = 0;
  logic [8:0]  exception_id = 0;
  logic [1:0]  exception_action = 0, match_size = 0;
  logic        cmp_match = 0, write_not_read = 0, stall = 0;
  logic [3:0]  comparator_index = 0;
  logic [31:0] match_pc = 32'h00008A42, match_addr = 32'h20005678;
  logic [31:0] match_value = 32'hCAFEBEEF, trc_payload;
  logic [7:0]  trc_header;
  logic        trc_valid, trc_ready, overflow_req;
  int          errors = 0, compares = 0, cyc = 0, lt, t;

  // 125 MHz clock
  always #4 pclk = ~pclk;

  hwtp_packetizer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .exc_valid(exc_valid), .exception_id(exception_id),
    .exception_action(exception_action), .core_pc(core_pc), .core_sleeping(core_sleeping),
    .cmp_match(cmp_match), .comparator_index(comparator_index), .match_pc(match_pc),
    .match_addr(match_addr), .match_value(match_value), .match_size(match_size),
    .write_not_read(write_not_read), .trc_valid(trc_valid), .trc_header(trc_header),
    .trc_payload(trc_payload), .trc_ready(trc_ready), .overflow_req(overflow_req));

  hwtp_mux_model u_mux (.pclk(pclk), .presetn(presetn), .trc_valid(trc_valid),
    .trc_header(trc_header), .trc_payload(trc_payload), .trc_ready(trc_ready),
    .overflow_req(overflow_req), .stall(stall));

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, exp, got);
    end
  endtask

  // one apb transfer: setup, then access until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one-cycle exception event
  task automatic exc(input logic [1:0] act);
    @(posedge pclk);
    exc_valid <= 1'b1;
    exception_id <= 9'h1A5;
    exception_action <= act;
    @(posedge pclk);
    exc_valid <= 1'b0;
  endtask

  // one-cycle comparator match
  task automatic mt(input logic [3:0] idx, input logic [1:0] sz, input logic w);
    @(posedge pclk);
    cmp_match <= 1'b1;
    comparator_index <= idx;
    match_size <= sz;
    write_not_read <= w;
    @(posedge pclk);
    cmp_match <= 1'b0;
  endtask

  // waits for the next logged packet and compares it
  task automatic pk(input logic [7:0] h, input logic [31:0] p);
    int k;
    k = 0;
    while (u_mux.hq.size() == 0 && k < 3000) begin
      k++;
      @(posedge pclk);
    end
    chk("arrived", 32'(u_mux.hq.size() > 0), 1);
    if (u_mux.hq.size() > 0) begin
      chk("header", u_mux.hq.pop_front(), h);
      chk("payload", u_mux.pq.pop_front(), p);
      lt = u_mux.tq.pop_front();
    end
  endtask

  task automatic clr();
    u_mux.hq.delete();
    u_mux.pq.delete();
    u_mux.tq.delete();
  endtask

  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      print_verdict();
    end
  end

  // test sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1, 12'h000, 32'h3E);
    apb(0, 12'h000, 0);
    chk("control", rd, 32'h3E);
    apb(1, 12'h010, 0);
    chk("slave error", er, 1);
    for (int a = 1; a < 4; a++) exc(a[1:0]);
    for (int a = 1; a < 4; a++) begin
      pk(8'h0E, {18'h0, a[1:0], 12'h1A5});
    end
    exc(2'h0);
    apb(1, 12'h004, 32'hE0);
    mt(4'h2, 2'h1, 1'b1);
    pk(8'h67, 32'h00008A42);
    pk(8'hAD, 32'h000000EF);
    mt(4'h1, 2'h3, 1'b0);
    pk(8'h5E, 32'h00005678);
    mt(4'h2, 2'h2, 1'b0);
    pk(8'h67, 32'h00008A42);
    pk(8'hA6, 32'h0000BEEF);
    mt(4'h2, 2'h0, 1'b0);
    pk(8'h67, 32'h00008A42);
    mt(4'h5, 2'h3, 1'b1);
    mt(4'h0, 2'h3, 1'b1);
    repeat (10) @(posedge pclk);
    chk("stray packets", u_mux.hq.size(), 0);
    stall <= 1'b1;
    for (int a = 0; a < 4; a++) exc(2'h1);
    repeat (4) @(posedge pclk);
    apb(0, 12'h008, 0);
    chk("drop count", rd, 2);
    chk("drop pulses", u_mux.ovf, 2);
    stall <= 1'b0;
    pk(8'h0E, 32'h000011A5);
    pk(8'h0E, 32'h000011A5);
    core_pc <= 32'h12345677;
    apb(1, 12'h000, 32'h1);
    clr();
    pk(8'h17, 32'h12345676);
    t = lt;
    core_sleeping <= 1'b1;
    pk(8'h15, 32'h0);
    chk("interval", lt - t, 64);
    apb(1, 12'h000, 32'h3);
    core_sleeping <= 1'b0;
    clr();
    pk(8'h17, 32'h12345676);
    t = lt;
    pk(8'h17, 32'h12345676);
    chk("tap interval", lt - t, 1024);
    apb(1, 12'h000, 32'h0);
    repeat (5) @(posedge pclk);
    clr();
    repeat (150) @(posedge pclk);
    chk("disabled", u_mux.hq.size(), 0);
    print_verdict();
  end
endmodule // hw_source_trace_packetizer_tb_top
